// ==== design/sscr_pkg.sv ====
// Purpose: Shared constants for the second synthesizer calibration registers.
// Assumes: One 100 MHz always-on clock; times are held in nanoseconds.
// Notes:   Cycle counts are derived from the times and the clock period.

package sscr_pkg;

  // ********************************************************
  // Register map and field layout
  // ********************************************************
  localparam logic [7:0] OFS_PUMP_WIDTH   = 8'h83;
  localparam logic [7:0] OFS_FILTER_ORDER = 8'h84;
  localparam logic [7:0] OFS_SETTLE_WAIT  = 8'h85;
  localparam logic [7:0] OFS_CAL_DELAY    = 8'h86;

  localparam int POS_STRETCH = 7;
  localparam int POS_FILT_LO = 0;
  localparam int POS_VCO_LO  = 0;
  localparam int POS_CLSD_LO = 2;
  localparam int POS_DLY_EN  = 0;

  localparam logic       RST_STRETCH = 1'h0;
  localparam logic [2:0] RST_FILTER  = 3'h3;
  localparam logic [1:0] RST_CLSD    = 2'h0;
  localparam logic [1:0] RST_VCO     = 2'h1;
  localparam logic       RST_DLY_EN  = 1'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CNT_W        = 25;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CLSD0_NS   = 30000;
  localparam int T_CLSD1_NS   = 300000;
  localparam int T_CLSD2_NS   = 30000000;
  localparam int T_CLSD3_NS   = 300000000;
  localparam int T_VCO0_NS    = 20000;
  localparam int T_VCO1_NS    = 400000;
  localparam int T_VCO2_NS    = 8000000;
  localparam int T_VCO3_NS    = 200000000;
  localparam int T_DELAY_NS   = 60000000;

  localparam int C_CLSD0 = (T_CLSD0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_CLSD1 = (T_CLSD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_CLSD2 = (T_CLSD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_CLSD3 = (T_CLSD3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_VCO0  = (T_VCO0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_VCO1  = (T_VCO1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_VCO2  = (T_VCO2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_VCO3  = (T_VCO3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DELAY = (T_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [CNT_W-1:0] sscr_cnt_t;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_DELAY,
    SQ_VCO,
    SQ_CLSD
  } sscr_seq_t;

endpackage

// ==== design/sscr_wait_timer.sv ====
// Purpose: Down-counter that measures one calibration wait.
// Assumes: Load value is at least one; start is a one-cycle pulse.
// Notes:   Expire is asserted in the last of load_val busy cycles.

module sscr_wait_timer
  import sscr_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  input  wire logic      start,
  input  wire sscr_cnt_t load_val,
  output logic           expire
);

  typedef struct packed {
    logic      busy;
    sscr_cnt_t cnt;
  } sscr_tmr_state_t;

  sscr_tmr_state_t st_ff;
  sscr_tmr_state_t nxt_st;

  assign expire = st_ff.busy && (st_ff.cnt == '0);

  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = load_val - sscr_cnt_t'(1);
    end else if (expire) begin
      nxt_st.busy = 1'b0;
    end else if (st_ff.busy) begin
      nxt_st.cnt = st_ff.cnt - sscr_cnt_t'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ==== design/sscr_top.sv ====
// Purpose: Control registers and calibration wait sequencer for the second
//          frequency synthesizer.
// Assumes: Register port and cal_req come from logic on ref_clk.
// Notes:   Wait codes are sampled when a calibration starts.

// Summary of operation
// - Pump stretch bit clear gives 200 ps pulse, set gives 600 ps; resets 0.
// - Loop filter field resets to 0x3 second order; 0x7 selects third order.
// - Closed-loop wait codes give 30 us, 300 us, 30 ms, 300 ms; reset 0.
// - VCO wait codes give 20 us, 400 us, 8 ms, 200 ms; reset 0x1.
// - Delay bit set postpones VCO calibration start by 60 ms; resets 0.
module sscr_top
  import sscr_pkg::*;
#(
  parameter sscr_cnt_t CLSD1_CYC = sscr_cnt_t'(C_CLSD1),
  parameter sscr_cnt_t CLSD2_CYC = sscr_cnt_t'(C_CLSD2),
  parameter sscr_cnt_t CLSD3_CYC = sscr_cnt_t'(C_CLSD3),
  parameter sscr_cnt_t VCO1_CYC  = sscr_cnt_t'(C_VCO1),
  parameter sscr_cnt_t VCO2_CYC  = sscr_cnt_t'(C_VCO2),
  parameter sscr_cnt_t VCO3_CYC  = sscr_cnt_t'(C_VCO3),
  parameter sscr_cnt_t DELAY_CYC = sscr_cnt_t'(C_DELAY)
)(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  input  wire logic       cal_req,
  output logic            pump_pulse_stretch,
  output logic      [2:0] loop_filter_order_sel,
  output logic      [1:0] closed_loop_settle_wait,
  output logic      [1:0] vco_settle_wait,
  output logic            cal_start_delay_en,
  output logic            cal_delay_active,
  output logic            vco_cal_active,
  output logic            closed_loop_active,
  output logic            cal_busy,
  output logic            cal_done
);

  // ********************************************************
  // Reset release
  // ********************************************************
  logic [1:0] rst_sync_ff;
  logic       rst_sync_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic       stretch;
    logic [2:0] filt;
    logic [1:0] clsd;
    logic [1:0] vco;
    logic       dly_en;
    logic [7:0] rd;
    sscr_seq_t  seq;
    logic [1:0] vco_code;
    logic [1:0] clsd_code;
    logic       dly_act;
    logic       vco_act;
    logic       cls_act;
    logic       busy;
    logic       done;
  } sscr_top_state_t;

  localparam sscr_top_state_t ST_RESET = '{
    stretch: RST_STRETCH, filt: RST_FILTER, clsd: RST_CLSD,
    vco: RST_VCO, dly_en: RST_DLY_EN, rd: RD_UNMAPPED, seq: SQ_IDLE,
    vco_code: RST_VCO, clsd_code: RST_CLSD, default: 1'b0};

  sscr_top_state_t st_ff;
  sscr_top_state_t nxt_st;
  logic            tmr_start;
  sscr_cnt_t       tmr_load;
  logic            tmr_expire;

  function automatic sscr_cnt_t vco_cycles(input logic [1:0] code);
    case (code)
      2'h0:    return sscr_cnt_t'(C_VCO0);
      2'h1:    return VCO1_CYC;
      2'h2:    return VCO2_CYC;
      default: return VCO3_CYC;
    endcase
  endfunction

  function automatic sscr_cnt_t clsd_cycles(input logic [1:0] code);
    case (code)
      2'h0:    return sscr_cnt_t'(C_CLSD0);
      2'h1:    return CLSD1_CYC;
      2'h2:    return CLSD2_CYC;
      default: return CLSD3_CYC;
    endcase
  endfunction

  always_comb begin
    nxt_st    = st_ff;
    tmr_start = 1'b0;
    tmr_load  = '0;
    nxt_st.done = 1'b0;
    // Register writes; reserved bits are dropped and read back as zero.
    if (reg_wr_en) begin
      if (reg_addr == OFS_PUMP_WIDTH) begin
        nxt_st.stretch = reg_wr_data[POS_STRETCH];
      end else if (reg_addr == OFS_FILTER_ORDER) begin
        nxt_st.filt = reg_wr_data[POS_FILT_LO +: 3];
      end else if (reg_addr == OFS_SETTLE_WAIT) begin
        nxt_st.clsd = reg_wr_data[POS_CLSD_LO +: 2];
        nxt_st.vco  = reg_wr_data[POS_VCO_LO +: 2];
      end else if (reg_addr == OFS_CAL_DELAY) begin
        nxt_st.dly_en = reg_wr_data[POS_DLY_EN];
      end
    end
    if (reg_rd_en) begin
      if (reg_addr == OFS_PUMP_WIDTH) begin
        nxt_st.rd = {st_ff.stretch, 7'h00};
      end else if (reg_addr == OFS_FILTER_ORDER) begin
        nxt_st.rd = {5'h00, st_ff.filt};
      end else if (reg_addr == OFS_SETTLE_WAIT) begin
        nxt_st.rd = {4'h0, st_ff.clsd, st_ff.vco};
      end else if (reg_addr == OFS_CAL_DELAY) begin
        nxt_st.rd = {7'h00, st_ff.dly_en};
      end else begin
        nxt_st.rd = RD_UNMAPPED;
      end
    end
    // Calibration sequencer; a request while busy is ignored.
    case (st_ff.seq)
      SQ_IDLE: begin
        if (cal_req) begin
          nxt_st.busy      = 1'b1;
          nxt_st.vco_code  = st_ff.vco;
          nxt_st.clsd_code = st_ff.clsd;
          tmr_start        = 1'b1;
          if (st_ff.dly_en) begin
            nxt_st.seq     = SQ_DELAY;
            nxt_st.dly_act = 1'b1;
            tmr_load       = DELAY_CYC;
          end else begin
            nxt_st.seq     = SQ_VCO;
            nxt_st.vco_act = 1'b1;
            tmr_load       = vco_cycles(st_ff.vco);
          end
        end
      end
      SQ_DELAY: begin
        if (tmr_expire) begin
          nxt_st.seq     = SQ_VCO;
          nxt_st.dly_act = 1'b0;
          nxt_st.vco_act = 1'b1;
          tmr_start      = 1'b1;
          tmr_load       = vco_cycles(st_ff.vco_code);
        end
      end
      SQ_VCO: begin
        if (tmr_expire) begin
          nxt_st.seq     = SQ_CLSD;
          nxt_st.vco_act = 1'b0;
          nxt_st.cls_act = 1'b1;
          tmr_start      = 1'b1;
          tmr_load       = clsd_cycles(st_ff.clsd_code);
        end
      end
      default: begin
        if (tmr_expire) begin
          nxt_st.seq     = SQ_IDLE;
          nxt_st.cls_act = 1'b0;
          nxt_st.busy    = 1'b0;
          nxt_st.done    = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // One shared counter suffices because the waits never overlap.
  sscr_wait_timer u_timer (
    .ref_clk  (ref_clk),
    .rst_n    (rst_sync_n),
    .start    (tmr_start),
    .load_val (tmr_load),
    .expire   (tmr_expire)
  );

  assign reg_rd_data             = st_ff.rd;
  assign pump_pulse_stretch      = st_ff.stretch;
  assign loop_filter_order_sel   = st_ff.filt;
  assign closed_loop_settle_wait = st_ff.clsd;
  assign vco_settle_wait         = st_ff.vco;
  assign cal_start_delay_en      = st_ff.dly_en;
  assign cal_delay_active        = st_ff.dly_act;
  assign vco_cal_active          = st_ff.vco_act;
  assign closed_loop_active      = st_ff.cls_act;
  assign cal_busy                = st_ff.busy;
  assign cal_done                = st_ff.done;

  // ********************************************************
  // Checks
  // ********************************************************
  logic [2:0]       ph_ff;
  logic [CNT_W:0]   ph_cnt_ff;
  logic             idle_req;

  assign idle_req = (st_ff.seq == SQ_IDLE) && cal_req;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ph_ff     <= 3'h0;
      ph_cnt_ff <= '0;
    end else begin
      ph_ff <= {st_ff.dly_act, st_ff.vco_act, st_ff.cls_act};
      if ({st_ff.dly_act, st_ff.vco_act, st_ff.cls_act} != ph_ff) begin
        ph_cnt_ff <= (CNT_W+1)'(1);
      end else begin
        ph_cnt_ff <= ph_cnt_ff + (CNT_W+1)'(1);
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_delay_end;
    $fell(st_ff.dly_act);
  endsequence

  sequence s_vco_end;
    $fell(st_ff.vco_act);
  endsequence

  a_stretch_write: assert property (
    reg_wr_en && reg_addr == OFS_PUMP_WIDTH
    |=> pump_pulse_stretch == $past(reg_wr_data[POS_STRETCH]))
    else $error("pump stretch bit did not follow write");
  a_filter_write: assert property (
    reg_wr_en && reg_addr == OFS_FILTER_ORDER
    |=> loop_filter_order_sel == $past(reg_wr_data[2:0]))
    else $error("loop filter field did not follow write");
  a_wait_write: assert property (
    reg_wr_en && reg_addr == OFS_SETTLE_WAIT
    |=> {closed_loop_settle_wait, vco_settle_wait} == $past(reg_wr_data[3:0]))
    else $error("wait fields did not follow write");
  a_delay_first: assert property (
    idle_req && cal_start_delay_en
    |=> cal_delay_active && !vco_cal_active && cal_busy)
    else $error("calibration delay did not start first");
  a_no_delay: assert property (
    idle_req && !cal_start_delay_en
    |=> vco_cal_active && !cal_delay_active)
    else $error("VCO wait did not start at once");
  // The counter trails the phase flags by one edge, just as $fell does.
  a_delay_length: assert property (
    s_delay_end |-> ph_cnt_ff == {1'b0, DELAY_CYC} && vco_cal_active)
    else $error("calibration delay length wrong");
  a_vco_length: assert property (
    s_vco_end |-> ph_cnt_ff == {1'b0, vco_cycles(st_ff.vco_code)})
    else $error("VCO wait length wrong");
  a_seq_order: assert property (
    s_vco_end |-> closed_loop_active ##0 !cal_delay_active)
    else $error("closed loop wait did not follow VCO wait");
  a_clsd_length: assert property (
    $fell(closed_loop_active)
    |-> ph_cnt_ff == {1'b0, clsd_cycles(st_ff.clsd_code)}
        && cal_done && !cal_busy)
    else $error("closed loop wait length wrong");

endmodule

// ==== bench/sscr_top_tb.sv ====
// Purpose: Self-checking bench for the second synthesizer control block.
// Assumes: Wait counts shortened by parameters; codes 0 keep fixed counts.
// Notes:   Inputs change on the falling edge, outputs are read there too.

`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module sscr_top_tb
  import sscr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ********************
  // Stimulus and wiring
  // ********************
  // Code 0 waits are 20 us and 30 us at a 10 ns period.
  localparam int V0  = 2000;
  localparam int C0  = 3000;
  localparam int DLY = 40;
  localparam int V1  = 20;
  localparam int V2  = 30;
  localparam int V3  = 50;
  localparam int C1  = 25;
  localparam int C2  = 35;
  localparam int C3  = 45;

  logic       ref_clk;
  logic       reset_n;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wr_data;
  logic       reg_rd_en;
  logic       cal_req;
  logic [7:0] reg_rd_data;
  logic       pump_pulse_stretch;
  logic [2:0] loop_filter_order_sel;
  logic [1:0] closed_loop_settle_wait;
  logic [1:0] vco_settle_wait;
  logic       cal_start_delay_en;
  logic       cal_delay_active;
  logic       vco_cal_active;
  logic       closed_loop_active;
  logic       cal_busy;
  logic       cal_done;
  logic [7:0] rd_val;
  int         error_cnt;
  int         cmp_count;

  sscr_top #(
    .CLSD1_CYC(sscr_cnt_t'(C1)),
    .CLSD2_CYC(sscr_cnt_t'(C2)),
    .CLSD3_CYC(sscr_cnt_t'(C3)),
    .VCO1_CYC (sscr_cnt_t'(V1)),
    .VCO2_CYC (sscr_cnt_t'(V2)),
    .VCO3_CYC (sscr_cnt_t'(V3)),
    .DELAY_CYC(sscr_cnt_t'(DLY))
  ) uut (
    .ref_clk                (ref_clk),
    .reset_n                (reset_n),
    .reg_addr               (reg_addr),
    .reg_wr_en              (reg_wr_en),
    .reg_wr_data            (reg_wr_data),
    .reg_rd_en              (reg_rd_en),
    .reg_rd_data            (reg_rd_data),
    .cal_req                (cal_req),
    .pump_pulse_stretch     (pump_pulse_stretch),
    .loop_filter_order_sel  (loop_filter_order_sel),
    .closed_loop_settle_wait(closed_loop_settle_wait),
    .vco_settle_wait        (vco_settle_wait),
    .cal_start_delay_en     (cal_start_delay_en),
    .cal_delay_active       (cal_delay_active),
    .vco_cal_active         (vco_cal_active),
    .closed_loop_active     (closed_loop_active),
    .cal_busy               (cal_busy),
    .cal_done               (cal_done)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ********************
  // Scenario tasks
  // ********************
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst;
    reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask

  // The strobe drops for a full cycle so back-to-back calls stay legal.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    rd_val = reg_rd_data;
    @(negedge ref_clk);
  endtask

  task automatic chk_regs(input logic [7:0] e3, e4, e5, e6);
    rd(OFS_PUMP_WIDTH);
    `CHK(rd_val, e3)
    rd(OFS_FILTER_ORDER);
    `CHK(rd_val, e4)
    rd(OFS_SETTLE_WAIT);
    `CHK(rd_val, e5)
    rd(OFS_CAL_DELAY);
    `CHK(rd_val, e6)
    `CHK(pump_pulse_stretch, e3[7])
    `CHK(loop_filter_order_sel, e4[2:0])
    `CHK(closed_loop_settle_wait, e5[3:2])
    `CHK(vco_settle_wait, e5[1:0])
    `CHK(cal_start_delay_en, e6[0])
  endtask

  task automatic t_defaults;
    `CHK(cal_busy, 1'b0)
    chk_regs(8'h00, 8'h03, 8'h01, 8'h00);
  endtask

  task automatic t_reg_access;
    wr(OFS_PUMP_WIDTH, 8'hff);
    wr(OFS_FILTER_ORDER, 8'hff);
    wr(OFS_SETTLE_WAIT, 8'hff);
    wr(OFS_CAL_DELAY, 8'hff);
    chk_regs(8'h80, 8'h07, 8'h0f, 8'h01);
    wr(OFS_PUMP_WIDTH, 8'h7f);
    wr(OFS_FILTER_ORDER, 8'h03);
    wr(OFS_SETTLE_WAIT, 8'h06);
    wr(OFS_CAL_DELAY, 8'hfe);
    wr(8'h87, 8'hff);
    wr(8'h82, 8'hff);
    rd(8'h87);
    `CHK(rd_val, 8'h00)
    chk_regs(8'h00, 8'h03, 8'h06, 8'h00);
    rst();
    t_defaults();
  endtask

  // A refused request and a code rewrite land mid-run; neither may
  // disturb the counts latched at the start.
  task automatic t_cal(input logic dly, input logic [1:0] vc, cl,
                       input int ed, ev, ec);
    int cd = 0;
    int cv = 0;
    int cc = 0;
    int cb = 0;
    int dn = 0;
    int ph = 0;
    int last = 0;
    int oh = 0;
    wr(OFS_CAL_DELAY, {7'h00, dly});
    wr(OFS_SETTLE_WAIT, {4'h0, cl, vc});
    reg_addr = OFS_SETTLE_WAIT;
    reg_wr_data = 8'h0f;
    cal_req = 1'b1;
    @(negedge ref_clk);
    for (int n = 0; n < 12000 && dn == 0; n++) begin
      cal_req = (n == 3);
      reg_wr_en = (n == 3);
      ph = cal_delay_active ? 1 : vco_cal_active ? 2 :
           closed_loop_active ? 3 : 0;
      oh = cal_delay_active + vco_cal_active + closed_loop_active;
      `CHK(oh <= 1, 1'b1)
      if (ph != 0) begin
        `CHK(ph >= last, 1'b1)
        last = ph;
      end
      cd += cal_delay_active;
      cv += vco_cal_active;
      cc += closed_loop_active;
      cb += cal_busy;
      if (cal_done === 1'b1) begin
        dn++;
        `CHK(cal_busy, 1'b0)
        `CHK(closed_loop_active, 1'b0)
      end
      @(negedge ref_clk);
    end
    if (dn == 0) begin
      error_cnt++;
      end_sim();
    end else begin
      `CHK(cal_done, 1'b0)
      `CHK(cd, ed)
      `CHK(cv, ev)
      `CHK(cc, ec)
      `CHK(cb, ed + ev + ec)
    end
  endtask

  task automatic t_abort;
    cal_req = 1'b1;
    @(negedge ref_clk);
    cal_req = 1'b0;
    repeat (5) @(negedge ref_clk);
    `CHK(cal_busy, 1'b1)
    `CHK(cal_delay_active, 1'b1)
    rst();
    t_defaults();
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    cal_req = 1'b0;
    rst();
    t_defaults();
    t_reg_access();
    t_cal(1'b0, 2'h0, 2'h0, 0, V0, C0);
    t_cal(1'b1, 2'h1, 2'h1, DLY, V1, C1);
    t_cal(1'b0, 2'h2, 2'h2, 0, V2, C2);
    t_cal(1'b1, 2'h3, 2'h3, DLY, V3, C3);
    t_abort();
    end_sim();
  end
endmodule
